// >>> hdl/ihw_irq_halt_ctrl.sv
// Function
// (R01) one interrupt entry at 0x0008; reset vector 0x0000, wake vector 0x0004
// (R02) request recurs at 32768 Hz, or 65536 Hz with double-rate option
// (R03) enable high and flag set: accept interrupt on the next clock
// (R04) on acceptance save next pc, page, memory high, carry, zero; load entry
// (R05) entering the interrupt clears the enable bit
// (R06) flag stays set on entry; software clears it
// (R07) return restores saved context and sets the enable bit
// (R08) one level only, never nested; accept only while enabled
// (R09) halt stops program counter and system clock
// (R10) rising edge on any wake-up port bit while halted wakes
// (R11) halt sets pc to 0x0004; advance after 64 stable clocks on wake
// (R12) reset beats wake; pc 0x0004 to 0x0000, advance after 64 clocks
// (R13) working memory retained throughout halt
// (R14) while halted only wake-up or reset return to normal mode
// (R15) each completed output cycle raises the request flag
// (R16) halt clears the audio output enable bit
// (R17) wake pins synchronised; stabilisation counted on restarted clock
// (R18) request while disabled stays pending, accepted after return
//
// Implementation choice: the APB register port.
module ihw_irq_halt_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire ihw_pkg::ihw_cmd_s coreCmd,
  input wire ihw_pkg::ihw_ctx_s coreCtx,
  input wire logic flagWrEn,
  input wire logic carryIn,
  input wire logic zeroIn,
  input wire logic doubleRateOption,
  // wake-up pins
  input wire logic [3:0] wakeupPortFirst,
  input wire logic [3:0] wakeupPortSecond,
  input wire logic [3:0] wakeupPortThird,
  // outputs to core
  output logic [12:0] pcOut,
  output logic pcLoad,
  output ihw_pkg::ihw_ctx_s restoreCtx,
  output logic restoreLoad,
  output logic sysClkEnable,
  output logic audioOutputEnable,
  output logic irqOut
);

  logic [3:0] statusReg;
  logic [3:0] ctrlReg;
  logic [2:0] evReg;
  logic [2:0] maskReg;
  ihw_pkg::ihw_ctx_s shadowReg;
  ihw_pkg::ihw_mode_e modeReg;
  logic [6:0] stableReg;
  logic [10:0] divReg;
  logic [11:0] wakeS1Reg, wakeS2Reg, wakeS3Reg;
  logic [2:0] resetStretchReg;
  logic inIrqReg;

  logic wrAcc, rdAcc;
  logic accept;
  logic cycleDone;
  logic wakeEdge;
  logic [2:0] evSet;

  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && !penable && !pwrite;
  // accept only in run mode while enabled, never while inside service
  // the core clock must already be running, else entry would race the wake vector
  assign accept = (modeReg == ihw_pkg::IHW_RUN) && sysClkEnable && ctrlReg[ihw_pkg::IRQEN_BIT] &&
                  statusReg[ihw_pkg::PWMREQ_BIT] && !inIrqReg && !coreCmd.halt; // R03 R08 R18
  assign wakeEdge = |(wakeS2Reg & ~wakeS3Reg); // R10
  assign cycleDone = (divReg == 11'd0) && (modeReg == ihw_pkg::IHW_RUN);
  assign evSet = {cycleDone, (modeReg == ihw_pkg::IHW_HALT) && wakeEdge, accept};

  // output-cycle divider, the request period
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      divReg <= ihw_pkg::REQ_DIV_BASE;
    end else if (modeReg != ihw_pkg::IHW_RUN) begin
      divReg <= ihw_pkg::REQ_DIV_BASE; // R09
    end else if (divReg == 11'd0) begin
      divReg <= doubleRateOption ? ihw_pkg::REQ_DIV_DOUBLE - 11'd1 : ihw_pkg::REQ_DIV_BASE - 11'd1; // R02
    end else begin
      divReg <= divReg - 11'd1;
    end
  end

  // wake pin synchronisers; the second and third stages feed the edge detector
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wakeS1Reg <= 12'h000;
      wakeS2Reg <= 12'h000;
      wakeS3Reg <= 12'h000;
    end else begin
      wakeS1Reg <= {wakeupPortThird, wakeupPortSecond, wakeupPortFirst}; // R17
      wakeS2Reg <= wakeS1Reg;
      wakeS3Reg <= wakeS2Reg;
    end
  end

  // status nibble: request flag plus carry and zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      statusReg <= ihw_pkg::STATUS_RST;
    end else begin
      if (wrAcc && paddr == ihw_pkg::STATUS_ADDR) begin
        statusReg[ihw_pkg::CARRY_BIT] <= pwdata[ihw_pkg::CARRY_BIT];
        statusReg[ihw_pkg::ZERO_BIT] <= pwdata[ihw_pkg::ZERO_BIT];
        statusReg[ihw_pkg::PWMREQ_BIT] <= pwdata[ihw_pkg::PWMREQ_BIT]; // R06
      end else if (coreCmd.retIrq && inIrqReg) begin
        statusReg[ihw_pkg::CARRY_BIT] <= shadowReg.carry; // R07
        statusReg[ihw_pkg::ZERO_BIT] <= shadowReg.zero;
      end else if (flagWrEn) begin
        statusReg[ihw_pkg::CARRY_BIT] <= carryIn;
        statusReg[ihw_pkg::ZERO_BIT] <= zeroIn;
      end
      // the completed cycle wins over a software clear in the same cycle
      if (cycleDone) begin
        statusReg[ihw_pkg::PWMREQ_BIT] <= 1'b1; // R15
      end
      statusReg[3] <= 1'b0;
    end
  end

  // control nibble: audio enable and interrupt enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlReg <= ihw_pkg::CTRL_RST;
    end else begin
      if (wrAcc && paddr == ihw_pkg::CTRL_ADDR && modeReg == ihw_pkg::IHW_RUN) begin
        ctrlReg[1:0] <= pwdata[1:0];
      end
      if (accept) begin
        ctrlReg[ihw_pkg::IRQEN_BIT] <= 1'b0; // R05
      end else if (coreCmd.retIrq && inIrqReg) begin
        ctrlReg[ihw_pkg::IRQEN_BIT] <= 1'b1; // R07
      end
      if (coreCmd.halt && modeReg == ihw_pkg::IHW_RUN) begin
        ctrlReg[ihw_pkg::AUDEN_BIT] <= 1'b0; // R16
      end
      ctrlReg[3:2] <= 2'b00;
    end
  end

  // service nesting guard and shadow context
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      inIrqReg <= 1'b0;
      shadowReg <= '0;
    end else if (accept) begin
      inIrqReg <= 1'b1; // R08
      shadowReg <= coreCtx; // R04
    end else if (coreCmd.retIrq) begin
      inIrqReg <= 1'b0;
    end
  end

  // run / halt / stabilise sequencing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      modeReg <= ihw_pkg::IHW_STAB;
      stableReg <= 7'd0;
      resetStretchReg <= 3'd0;
    end else begin
      resetStretchReg <= {resetStretchReg[1:0], 1'b1};
      case (modeReg)
        ihw_pkg::IHW_RUN: begin
          if (coreCmd.halt) begin
            modeReg <= ihw_pkg::IHW_HALT; // R09
          end
        end
        ihw_pkg::IHW_HALT: begin
          // instruction strobes are ignored here; only pins leave halt
          if (wakeEdge) begin
            modeReg <= ihw_pkg::IHW_STAB; // R10 R14
            stableReg <= 7'd0;
          end
        end
        ihw_pkg::IHW_STAB: begin
          if (stableReg == ihw_pkg::STABLE_CLKS - 7'd1) begin
            modeReg <= ihw_pkg::IHW_RUN; // R11 R12 R17
          end else begin
            stableReg <= stableReg + 7'd1;
          end
        end
        default: begin
          modeReg <= ihw_pkg::IHW_RUN;
        end
      endcase
    end
  end

  // program counter steering
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pcOut <= ihw_pkg::VEC_RESET; // R12
      pcLoad <= 1'b1;
      restoreCtx <= '0;
      restoreLoad <= 1'b0;
    end else begin
      pcLoad <= 1'b0;
      restoreLoad <= 1'b0;
      if (modeReg == ihw_pkg::IHW_RUN && coreCmd.halt) begin
        pcOut <= ihw_pkg::VEC_WAKE; // R11
        pcLoad <= 1'b1;
      end else if (accept) begin
        pcOut <= ihw_pkg::VEC_IRQ; // R01 R04
        pcLoad <= 1'b1;
      end else if (coreCmd.retIrq && inIrqReg && modeReg == ihw_pkg::IHW_RUN) begin
        restoreCtx <= shadowReg; // R07
        restoreLoad <= 1'b1;
        pcOut <= shadowReg.pc;
        pcLoad <= 1'b1;
      end else if (modeReg != ihw_pkg::IHW_RUN && resetStretchReg[2] == 1'b0) begin
        pcLoad <= 1'b1;
      end
    end
  end

  // core clock gate; working memory simply keeps its contents while gated
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sysClkEnable <= 1'b0;
      audioOutputEnable <= 1'b0;
    end else begin
      sysClkEnable <= (modeReg == ihw_pkg::IHW_RUN) && !coreCmd.halt; // R09 R13
      audioOutputEnable <= ctrlReg[ihw_pkg::AUDEN_BIT];
    end
  end

  // sticky event bits, write one to clear; set beats clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      evReg <= 3'h0;
      maskReg <= ihw_pkg::IRQ_MASK_RST;
    end else begin
      if (wrAcc && paddr == ihw_pkg::IRQ_STAT_ADDR) begin
        evReg <= (evReg & ~pwdata[2:0]) | evSet;
      end else begin
        evReg <= evReg | evSet;
      end
      if (wrAcc && paddr == ihw_pkg::IRQ_MASK_ADDR) begin
        maskReg <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(evReg & maskReg);
    end
  end

  // apb: zero-wait, read data captured in the setup cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (rdAcc) begin
        if (paddr == ihw_pkg::STATUS_ADDR) begin
          prdata <= {28'h0, statusReg};
        end else if (paddr == ihw_pkg::CTRL_ADDR) begin
          prdata <= {28'h0, ctrlReg};
        end else if (paddr == ihw_pkg::IRQ_STAT_ADDR) begin
          prdata <= {29'h0, evReg};
        end else if (paddr == ihw_pkg::IRQ_MASK_ADDR) begin
          prdata <= {29'h0, maskReg};
        end else if (paddr == ihw_pkg::MODE_ADDR) begin
          prdata <= {30'h0, modeReg};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
      if (psel && !penable && paddr != ihw_pkg::STATUS_ADDR && paddr != ihw_pkg::CTRL_ADDR &&
          paddr != ihw_pkg::IRQ_STAT_ADDR && paddr != ihw_pkg::IRQ_MASK_ADDR && paddr != ihw_pkg::MODE_ADDR) begin
        pslverr <= 1'b1;
      end
    end
  end

endmodule

// >>> hdl/ihw_pkg.sv
package ihw_pkg;
  // register offsets (nibble registers, one aligned word each)
  localparam logic [7:0] STATUS_IDX = 8'h00;
  localparam logic [7:0] CTRL_IDX = 8'h09;
  localparam logic [11:0] STATUS_ADDR = 12'h000;
  localparam logic [11:0] CTRL_ADDR = 12'h024;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h040;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h044;
  localparam logic [11:0] MODE_ADDR = 12'h048;
  // field positions
  localparam int ZERO_BIT = 0;
  localparam int CARRY_BIT = 1;
  localparam int PWMREQ_BIT = 2;
  localparam int AUDEN_BIT = 0;
  localparam int IRQEN_BIT = 1;
  localparam int EV_ENTRY_BIT = 0;
  localparam int EV_WAKE_BIT = 1;
  localparam int EV_REQ_BIT = 2;
  // reset values
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  // vectors
  localparam logic [12:0] VEC_RESET = 13'h0000;
  localparam logic [12:0] VEC_WAKE = 13'h0004;
  localparam logic [12:0] VEC_IRQ = 13'h0008;
  // timing
  localparam int SYS_HZ = 40000000;
  localparam int REQ_HZ_BASE = 32768;
  localparam int REQ_HZ_DOUBLE = 65536;
  localparam logic [10:0] REQ_DIV_BASE = 11'(SYS_HZ / REQ_HZ_BASE);
  localparam logic [10:0] REQ_DIV_DOUBLE = 11'(SYS_HZ / REQ_HZ_DOUBLE);
  localparam logic [6:0] STABLE_CLKS = 7'd64;

  typedef enum logic [1:0] {
    IHW_RUN = 2'b00,
    IHW_HALT = 2'b01,
    IHW_STAB = 2'b11
  } ihw_mode_e;

  // context shadowed on interrupt entry
  typedef struct packed {
    logic [12:0] pc;
    logic [3:0] page;
    logic [3:0] memHigh;
    logic carry;
    logic zero;
  } ihw_ctx_s;

  // core instruction strobes
  typedef struct packed {
    logic retIrq;
    logic halt;
    logic stepPc;
  } ihw_cmd_s;
endpackage

// >>> verification/ihw_core_model.sv
module ihw_core_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // from controller
  input wire logic [12:0] pcOut,
  input wire logic pcLoad,
  input wire ihw_pkg::ihw_ctx_s restoreCtx,
  input wire logic restoreLoad,
  // bench seeding
  input wire ihw_pkg::ihw_ctx_s seed,
  input wire logic seedLoad,
  // live context
  output ihw_pkg::ihw_ctx_s coreCtx
);
  timeunit 1ns;
  timeprecision 1ps;
  // pc holds between loads so the shadowed value is unambiguous
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) coreCtx <= '0;
    else if (seedLoad) coreCtx <= seed;
    else if (restoreLoad) coreCtx <= restoreCtx;
    else if (pcLoad) coreCtx.pc <= pcOut;
  end
endmodule

// >>> verification/ihw_irq_halt_ctrl_bench.sv
module ihw_irq_halt_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic flagWrEn = 1'b0, carryIn = 1'b0, zeroIn = 1'b0, dbl = 1'b0, seedLoad = 1'b0;
  logic [11:0] wake = 12'h000;
  ihw_pkg::ihw_cmd_s cmd = '0;
  ihw_pkg::ihw_ctx_s ctx, rctx, saved, seed = '0;
  logic [12:0] pcOut;
  logic pcLoad, rLoad, clkEn, audEn, irqOut;
  logic [32:0] re;
  logic [32:0] rdQ[$];
  logic [12:0] pcQ[$];
  int err_total = 0, samples_checked = 0, cycles = 0, n, t0, dv;
  ihw_irq_halt_ctrl i_ihw_irq_halt_ctrl (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .coreCmd(cmd), .coreCtx(ctx), .flagWrEn, .carryIn, .zeroIn,
    .doubleRateOption(dbl), .wakeupPortFirst(wake[3:0]), .wakeupPortSecond(wake[7:4]),
    .wakeupPortThird(wake[11:8]), .pcOut, .pcLoad, .restoreCtx(rctx), .restoreLoad(rLoad),
    .sysClkEnable(clkEn), .audioOutputEnable(audEn), .irqOut);
  ihw_core_model i_ihw_core_model (.sys_clk, .resetn, .pcOut, .pcLoad, .restoreCtx(rctx),
    .restoreLoad(rLoad), .seed, .seedLoad, .coreCtx(ctx));
  always #12.5 sys_clk = ~sys_clk;
  task tally_and_finish;
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rdQ.push_back(e);
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task pulse(input logic h);
    @(posedge sys_clk);
    cmd <= {~h, h, 1'b0};
    @(posedge sys_clk);
    cmd <= '0;
    @(negedge sys_clk);
  endtask
  // reset-time loads at vector zero are judged separately
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      re = rdQ.size() ? rdQ.pop_front() : 33'h1DEADBEEF;
      cmp("pslverr", 32'(re[32]), 32'(pslverr));
      if (!re[32]) cmp("prdata", re[31:0], prdata);
    end
    if (resetn && pcLoad === 1'b1 && pcOut !== 13'h0000)
      cmp("pcOut", pcQ.size() ? 32'(pcQ.pop_front()) : 32'h0, 32'(pcOut));
  end
  initial begin
    n = $urandom(32'h9617);
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    while (clkEn !== 1'b1) @(posedge sys_clk);
    rd(ihw_pkg::STATUS_ADDR, 32'(ihw_pkg::STATUS_RST));
    rd(ihw_pkg::CTRL_ADDR, 32'(ihw_pkg::CTRL_RST));
    rd(ihw_pkg::IRQ_MASK_ADDR, 32'(ihw_pkg::IRQ_MASK_RST));
    apb(1'b0, 12'h0FC, 32'h0, {1'b1, 32'h0});
    seed <= ihw_pkg::ihw_ctx_s'($urandom) | 23'h040000;
    @(posedge sys_clk);
    seedLoad <= 1'b1;
    flagWrEn <= 1'b1;
    carryIn <= seed.carry;
    zeroIn <= seed.zero;
    @(posedge sys_clk);
    seedLoad <= 1'b0;
    flagWrEn <= 1'b0;
    rd(ihw_pkg::STATUS_ADDR, {30'h0, seed.carry, seed.zero});
    wr(ihw_pkg::IRQ_MASK_ADDR, 32'h7);
    pcQ.push_back(ihw_pkg::VEC_IRQ);
    wr(ihw_pkg::CTRL_ADDR, 32'h3);
    saved = ctx;
    while (pcLoad !== 1'b1) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    cmp("irqOut", 32'h1, 32'(irqOut));
    rd(ihw_pkg::STATUS_ADDR, {29'h0, 1'b1, seed.carry, seed.zero});
    rd(ihw_pkg::CTRL_ADDR, 32'h1);
    repeat (1300) @(posedge sys_clk);
    pcQ.push_back(saved.pc);
    pcQ.push_back(ihw_pkg::VEC_IRQ);
    pulse(1'b0);
    cmp("restoreLoad", 32'h1, 32'(rLoad));
    cmp("restoreCtx", 32'(saved), 32'(rctx));
    repeat (6) @(posedge sys_clk);
    cmp("pending entry", 32'h0, 32'(pcQ.size()));
    wr(ihw_pkg::STATUS_ADDR, {30'h0, seed.carry, seed.zero});
    wr(ihw_pkg::IRQ_MASK_ADDR, 32'h0);
    wr(ihw_pkg::IRQ_STAT_ADDR, 32'h7);
    repeat (2) @(posedge sys_clk);
    cmp("irqOut masked", 32'h0, 32'(irqOut));
    wr(ihw_pkg::IRQ_MASK_ADDR, 32'h4);
    for (int d = 0; d < 2; d++) begin
      dbl <= d[0];
      dv = d ? ihw_pkg::REQ_DIV_DOUBLE : ihw_pkg::REQ_DIV_BASE;
      wr(ihw_pkg::IRQ_STAT_ADDR, 32'h7);
      // irqOut lags the clear by a cycle; wait for it to drop before timing
      while (irqOut !== 1'b0) @(posedge sys_clk);
      while (irqOut !== 1'b1) @(posedge sys_clk);
      t0 = cycles;
      wr(ihw_pkg::IRQ_STAT_ADDR, 32'h7);
      rd(ihw_pkg::IRQ_STAT_ADDR, 32'h0);
      while (irqOut !== 1'b1) @(posedge sys_clk);
      cmp("period", 32'h1, 32'(cycles - t0 >= dv - 1 && cycles - t0 <= dv + 1));
    end
    for (int p = 0; p < 3; p++) begin
      wr(ihw_pkg::CTRL_ADDR, 32'h1);
      pcQ.push_back(ihw_pkg::VEC_WAKE);
      pulse(1'b1);
      cmp("sysClkEnable", 32'h0, 32'(clkEn));
      wr(ihw_pkg::CTRL_ADDR, 32'h3);
      rd(ihw_pkg::CTRL_ADDR, 32'h0);
      wake[4 * p + $urandom_range(3, 0)] <= 1'b1;
      t0 = cycles;
      while (clkEn !== 1'b1) @(posedge sys_clk);
      cmp("wake delay", 32'h1, 32'(cycles - t0 >= 64 && cycles - t0 <= 72));
      wake <= 12'h000;
    end
    pcQ.push_back(ihw_pkg::VEC_WAKE);
    pulse(1'b1);
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b0;
    @(negedge sys_clk);
    cmp("pcOut reset", 32'(ihw_pkg::VEC_RESET), 32'(pcOut));
    @(posedge sys_clk);
    resetn <= 1'b1;
    t0 = cycles;
    while (clkEn !== 1'b1) @(posedge sys_clk);
    cmp("reset delay", 32'h1, 32'(cycles - t0 >= 63 && cycles - t0 <= 66));
    cmp("queues", 32'h0, 32'(rdQ.size() + pcQ.size()));
    tally_and_finish();
  end
endmodule

// >>> verification/ihw_irq_halt_ctrl_checker.sv
module ihw_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire ihw_pkg::ihw_cmd_s coreCmd,
  input wire logic [12:0] pcOut,
  input wire logic pcLoad,
  input wire ihw_pkg::ihw_ctx_s restoreCtx,
  input wire logic restoreLoad,
  input wire logic sysClkEnable,
  input wire logic audioOutputEnable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [6:0] lowCnt;
  // saturates so a long halt cannot wrap into a false short count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) lowCnt <= 7'h00;
    else if (sysClkEnable) lowCnt <= 7'h00;
    else if (lowCnt != 7'h7F) lowCnt <= lowCnt + 7'h01;
  end
  sequence s_halt;
    coreCmd.halt && sysClkEnable;
  endsequence
  sequence s_park;
    pcLoad && pcOut == ihw_pkg::VEC_WAKE && !sysClkEnable;
  endsequence
  sequence s_entry;
    pcLoad && pcOut == ihw_pkg::VEC_IRQ;
  endsequence
  a_halt_entry: assert property (s_halt |=> s_park)
    else $error("halt entry wrong");
  a_audio_cut: assert property (s_halt |=> ##[0:1] !audioOutputEnable)
    else $error("audio not cut on halt");
  a_audio_halt: assert property (!sysClkEnable && $past(!sysClkEnable) |-> !audioOutputEnable)
    else $error("audio on while halted");
  a_stab_count: assert property ($rose(sysClkEnable) |-> lowCnt >= 7'h3F)
    else $error("clock restarted early");
  a_no_halt_irq: assert property (!sysClkEnable && pcLoad |-> pcOut != ihw_pkg::VEC_IRQ)
    else $error("entry while halted");
  a_entry_once: assert property (s_entry |=> !(pcLoad && pcOut == ihw_pkg::VEC_IRQ))
    else $error("nested entry");
  a_entry_run: assert property (s_entry |-> $past(sysClkEnable))
    else $error("entry outside run");
  a_ret_load: assert property (restoreLoad |-> pcLoad && pcOut == restoreCtx.pc)
    else $error("return pc wrong");
  a_ret_cause: assert property (restoreLoad |-> $past(coreCmd.retIrq))
    else $error("restore without return");
  a_apb_ready: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("apb wait state");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule
bind ihw_irq_halt_ctrl ihw_checker i_ihw_checker (.sys_clk, .resetn, .psel, .penable, .pready, .pslverr,
  .coreCmd, .pcOut, .pcLoad, .restoreCtx, .restoreLoad, .sysClkEnable, .audioOutputEnable);
